//--- event_count_bank.sv
// file: small register bank holding the four event counters
`timescale 1ns/100ps

module event_count_bank #(
    parameter int COUNT_WIDTH = 32
) (
    input  wire logic                                hclk,        // core clock
    input  wire logic                                hresetn,     // async reset, active low
    input  wire logic                                clear,       // zero every counter
    input  wire perf_monitor_pkg::count_access_s     access,      // write strobe, index and data
    input  wire logic [perf_monitor_pkg::NUM_COUNTERS-1:0] bump,  // increment request per counter
    input  wire logic [1:0]                          read_index,  // counter to present
    output logic      [COUNT_WIDTH-1:0]              read_data    // registered read data
);

    typedef struct packed {
        logic [perf_monitor_pkg::NUM_COUNTERS-1:0][COUNT_WIDTH-1:0] count;
        logic [COUNT_WIDTH-1:0]                                      rdata;
    } bank_state_s;

    bank_state_s state;
    bank_state_s next_state;

    always_comb begin
        next_state = state;
        for (int i = 0; i < perf_monitor_pkg::NUM_COUNTERS; i++) begin
            if (clear) begin
                next_state.count[i] = '0;
            end else if (access.write && access.index == 2'(i)) begin
                // the written value wins over a coincident increment
                next_state.count[i] = access.data[COUNT_WIDTH-1:0];
            end else if (bump[i]) begin
                // plain modulo add, overflow wraps silently
                next_state.count[i] = state.count[i] + COUNT_WIDTH'(1);
            end
        end
        next_state.rdata = state.count[read_index];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign read_data = state.rdata;

endmodule

//--- event_source_model.sv
// partner model: cache and commit-stage event pulse source
`timescale 1ns/100ps

module event_source_model (
    input  wire logic                    hclk,    // core clock
    input  wire logic                    hresetn, // async reset, active low
    input  wire logic                    start,   // launch a pulse train
    input  wire logic [15:0]             mask,    // encodings to pulse
    input  wire logic [7:0]              count,   // pulses in the train
    input  wire logic [3:0]              gap,     // idle cycles between pulses
    output perf_monitor_pkg::event_pulses_s events, // one high cycle per occurrence
    output logic                         busy     // train still running
);
    logic [7:0] left;
    logic [3:0] idle_n;
    // pulses arrive already qualified by the caches and taken at commit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            events <= '0;
            left   <= 8'h00;
            idle_n <= 4'h0;
        end else if (start) begin
            events <= mask;
            left   <= count - 8'h01;
            idle_n <= gap;
        end else if (left != 8'h00 && idle_n == 4'h0) begin
            events <= mask;
            left   <= left - 8'h01;
            idle_n <= gap;
        end else begin
            events <= '0;
            if (idle_n != 4'h0) begin
                idle_n <= idle_n - 4'h1;
            end
        end
    end
    assign busy = left != 8'h00 || events != '0;
endmodule

//--- perf_check_monitor.sv
// checker: bus answer, fault pulse and register readback assertions
`timescale 1ns/100ps

module perf_check_monitor (
    input wire logic        hclk,                      // core clock
    input wire logic        hresetn,                   // async reset, active low
    input wire logic        hsel,                      // slave select
    input wire logic [31:0] haddr,                     // byte address
    input wire logic [1:0]  htrans,                    // transfer type
    input wire logic        hwrite,                    // write when high
    input wire logic [3:0]  hprot,                     // privilege in bit 1
    input wire logic [31:0] hwdata,                    // write data
    input wire logic        hready,                    // bus ready
    input wire logic [31:0] hrdata,                    // read data
    input wire logic        hreadyout,                 // slave ready
    input wire logic        hresp,                     // response
    input wire logic        control_space_write_fault  // user write fault pulse
);
    // ----
    // helper state: data phase and a shadow of the control register
    // ----
    logic        take;
    logic        uw;
    logic        sw;
    logic        dp;
    logic        dp_wr;
    logic        dp_user;
    logic [7:0]  dp_addr;
    logic [31:0] shadow;
    logic        hold_ok;
    logic [31:0] hold_val;
    logic        rd_ctl;
    logic        rd_cyc;
    assign take   = hsel & hready & htrans[1];
    assign uw     = take & hwrite & ~hprot[1];
    assign sw     = take & hwrite & hprot[1];
    assign rd_ctl = dp & ~dp_wr & (dp_addr == perf_monitor_pkg::ADDR_CONTROL);
    assign rd_cyc = dp & ~dp_wr & (dp_addr == perf_monitor_pkg::ADDR_CYCLE);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp       <= 1'b0;
            dp_wr    <= 1'b0;
            dp_user  <= 1'b0;
            dp_addr  <= 8'h00;
            shadow   <= perf_monitor_pkg::CONTROL_RESET;
            hold_ok  <= 1'b0;
            hold_val <= 32'h0000_0000;
        end else begin
            dp      <= take;
            dp_wr   <= hwrite;
            dp_user <= ~hprot[1];
            dp_addr <= haddr[7:0];
            if (dp && dp_wr && !dp_user && dp_addr == perf_monitor_pkg::ADDR_CONTROL) begin
                shadow   <= hwdata & perf_monitor_pkg::CONTROL_MASK;
                hold_ok  <= hwdata[1] & ~hwdata[0];
                hold_val <= 32'h0000_0000;
            end else if (rd_cyc && !shadow[0]) begin
                hold_ok  <= 1'b1;
                hold_val <= hrdata;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_okay_ready: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    a_user_fault: assert property (uw |-> ##2 control_space_write_fault)
        else $error("user write gave no fault pulse");
    a_fault_cause: assert property (control_space_write_fault |-> $past(uw, 2))
        else $error("fault pulse without user write");
    a_super_quiet: assert property (sw |-> ##2 !control_space_write_fault)
        else $error("supervisor write faulted");
    a_control_readback: assert property (rd_ctl |-> hrdata == shadow)
        else $error("control read differs from last write");
    a_control_zero_bits: assert property (rd_ctl |-> hrdata[11:1] == 11'h000)
        else $error("control reserved or clear bit read nonzero");
    a_unmapped_zero: assert property (dp && !dp_wr && dp_addr == perf_monitor_pkg::ADDR_STATUS |-> hrdata == 32'h0)
        else $error("unmapped read nonzero");
    a_cycle_frozen: assert property (rd_cyc && hold_ok && !shadow[0] |-> hrdata == hold_val)
        else $error("cycle count moved while stopped");
endmodule

bind performance_event_monitor perf_check_monitor u_perf_check_monitor (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hprot(hprot), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .control_space_write_fault(control_space_write_fault)
);

//--- perf_monitor_pkg.sv
// package: register map, field layout and event encodings of the performance monitor
package perf_monitor_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_CYCLE   = 8'h04;
    localparam logic [7:0] ADDR_COUNT0  = 8'h10;
    localparam logic [7:0] ADDR_STATUS  = 8'h08;
    localparam int         ADDR_BITS    = 8;
    localparam int         NUM_COUNTERS = 4;
    localparam int         COUNTER_STEP = 4;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int          ENABLE_BIT    = 0;
    localparam int          CLEAR_BIT     = 1;
    localparam int          SELECT_LSB    = 12;
    localparam int          SELECT_WIDTH  = 5;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] CONTROL_MASK  = 32'hFFFF_F001;
    localparam logic [31:0] COUNT_RESET   = 32'h0000_0000;
    localparam int          NUM_EVENTS    = 16;

    // ------------------------------------------------------------
    // event encodings
    // ------------------------------------------------------------
    localparam logic [4:0] EV_DATA_CACHE_HIT       = 5'h00;
    localparam logic [4:0] EV_DATA_CACHE_MISS      = 5'h01;
    localparam logic [4:0] EV_DATA_CACHE_STALL     = 5'h02;
    localparam logic [4:0] EV_PREFETCH_ISSUED      = 5'h03;
    localparam logic [4:0] EV_PREFETCH_BUFFER_HIT  = 5'h04;
    localparam logic [4:0] EV_WRITE_BUFFER_HIT     = 5'h05;
    localparam logic [4:0] EV_INSTR_CACHE_HIT      = 5'h06;
    localparam logic [4:0] EV_INSTR_CACHE_MISS     = 5'h07;
    localparam logic [4:0] EV_INSTR_CACHE_STALL    = 5'h08;
    localparam logic [4:0] EV_ISSUE_STARVED        = 5'h09;
    localparam logic [4:0] EV_BUNDLE_EXECUTED      = 5'h0A;
    localparam logic [4:0] EV_LOAD_STORE_EXECUTED  = 5'h0B;
    localparam logic [4:0] EV_BRANCH_TAKEN         = 5'h0C;
    localparam logic [4:0] EV_BRANCH_NOT_TAKEN     = 5'h0D;
    localparam logic [4:0] EV_EXCEPTION            = 5'h0E;
    localparam logic [4:0] EV_INTERRUPT            = 5'h0F;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    // raw event pulses, one bit per encoding 0..15
    typedef struct packed {
        logic interrupt_taken;
        logic exception_taken;
        logic branch_not_taken;
        logic branch_taken;
        logic load_store_executed;
        logic bundle_executed;
        logic issue_starved_cycles;
        logic instr_cache_stall_cycles;
        logic instr_cache_miss;
        logic instr_cache_hit;
        logic write_buffer_hit;
        logic prefetch_buffer_hit;
        logic prefetch_issued;
        logic data_cache_stall_cycles;
        logic data_cache_miss;
        logic data_cache_hit;
    } event_pulses_s;

    // one write reaching the counter bank
    typedef struct packed {
        logic        write;
        logic [1:0]  index;
        logic [31:0] data;
    } count_access_s;

endpackage

//--- performance_event_monitor.sv
// file: performance event monitor with an AHB-Lite register slave
`timescale 1ns/100ps

module performance_event_monitor #(
    parameter int COUNT_WIDTH = 32
) (
    input  wire logic                          hclk,           // core clock
    input  wire logic                          hresetn,        // async reset, active low
    input  wire logic                          hsel,           // slave select
    input  wire logic [31:0]                   haddr,          // byte address
    input  wire logic [1:0]                    htrans,         // transfer type
    input  wire logic                          hwrite,         // write when high
    input  wire logic [2:0]                    hsize,          // transfer size
    input  wire logic [3:0]                    hprot,          // bit 1 high marks privileged
    input  wire logic [31:0]                   hwdata,         // write data
    input  wire logic                          hready,         // bus ready in
    output logic      [31:0]                   hrdata,         // read data
    output logic                               hreadyout,      // slave ready
    output logic                               hresp,          // always OKAY
    input  wire perf_monitor_pkg::event_pulses_s events,       // per-cycle event pulses
    output logic                               control_space_write_fault // user write attempt pulse
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PHASE_IDLE,
        PHASE_WRITE,
        PHASE_READ
    } phase_e;

    typedef struct packed {
        phase_e                 phase;
        logic [perf_monitor_pkg::ADDR_BITS-1:0] addr;
        logic                   privileged;
        logic [31:0]            control;
        logic [COUNT_WIDTH-1:0] cycles;
        logic                   fault;
        logic [31:0]            rdata;
    } monitor_state_s;

    monitor_state_s state;
    monitor_state_s next_state;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [perf_monitor_pkg::SELECT_WIDTH-1:0] select_of(
        input logic [31:0] ctrl,
        input int          n
    );
        return ctrl[perf_monitor_pkg::SELECT_LSB + n*perf_monitor_pkg::SELECT_WIDTH +: perf_monitor_pkg::SELECT_WIDTH];
    endfunction

    // high when the address falls inside the event counter window
    function automatic logic counter_hit(
        input logic [perf_monitor_pkg::ADDR_BITS-1:0] a
    );
        return a >= perf_monitor_pkg::ADDR_COUNT0
            && a < perf_monitor_pkg::ADDR_COUNT0
                   + perf_monitor_pkg::ADDR_BITS'(perf_monitor_pkg::NUM_COUNTERS * perf_monitor_pkg::COUNTER_STEP);
    endfunction

    function automatic logic [1:0] counter_index(
        input logic [perf_monitor_pkg::ADDR_BITS-1:0] a
    );
        logic [perf_monitor_pkg::ADDR_BITS-1:0] off;
        off = a - perf_monitor_pkg::ADDR_COUNT0;
        return off[3:2];
    endfunction

    // ------------------------------------------------------------
    // event selection
    // ------------------------------------------------------------
    logic [perf_monitor_pkg::NUM_COUNTERS-1:0] bump;
    logic [perf_monitor_pkg::NUM_EVENTS-1:0]   event_vec;
    logic [perf_monitor_pkg::SELECT_WIDTH-1:0] sel;

    // the cache and commit stages qualify their pulses; commit events arrive
    // only for committed bundles, so nothing speculative is counted here
    assign event_vec = events;

    always_comb begin
        bump = '0;
        sel  = '0;
        for (int i = 0; i < perf_monitor_pkg::NUM_COUNTERS; i++) begin
            sel = select_of(state.control, i);
            // top select bit marks a reserved encoding with no event
            if (state.control[perf_monitor_pkg::ENABLE_BIT] && !sel[perf_monitor_pkg::SELECT_WIDTH-1]) begin
                // encodings 0..15 map straight onto the pulse vector
                bump[i] = event_vec[sel[perf_monitor_pkg::SELECT_WIDTH-2:0]];
            end
        end
    end

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic                                   take;
    logic                                   data_write;
    logic                                   clear_all;
    perf_monitor_pkg::count_access_s        count_access;
    logic [COUNT_WIDTH-1:0]                 count_rdata;
    logic [1:0]                             read_index;

    assign take       = hsel && hready && htrans[1];
    // user-mode writes are dropped and flagged
    assign data_write = state.phase == PHASE_WRITE && state.privileged;
    assign clear_all  = data_write && state.addr == perf_monitor_pkg::ADDR_CONTROL
                        && hwdata[perf_monitor_pkg::CLEAR_BIT];

    always_comb begin
        count_access.write = data_write && counter_hit(state.addr);
        count_access.index = counter_index(state.addr);
        count_access.data  = hwdata;
    end

    assign read_index = counter_index(haddr[perf_monitor_pkg::ADDR_BITS-1:0]);

    event_count_bank #(
        .COUNT_WIDTH (COUNT_WIDTH)
    ) counters (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .clear      (clear_all),
        .access     (count_access),
        .bump       (bump),
        .read_index (read_index),
        .read_data  (count_rdata)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state       = state;
        next_state.fault = 1'b0;
        next_state.rdata = '0;

        // one counter per enabled clock, modulo wrap with no flag
        if (state.control[perf_monitor_pkg::ENABLE_BIT]) begin
            next_state.cycles = state.cycles + COUNT_WIDTH'(1);
        end

        case (state.phase)
            PHASE_WRITE: begin
                if (data_write && state.addr == perf_monitor_pkg::ADDR_CONTROL) begin
                    // stored without the self-clearing bit and reserved bits
                    next_state.control = hwdata & perf_monitor_pkg::CONTROL_MASK;
                end
                if (clear_all) begin
                    next_state.cycles = '0;
                end
                // cycle counter address ignores any write
                next_state.fault = !state.privileged;
            end
            PHASE_READ: begin
            end
            PHASE_IDLE: begin
            end
            default: begin
                next_state.phase = PHASE_IDLE;
            end
        endcase

        if (take) begin
            next_state.addr       = haddr[perf_monitor_pkg::ADDR_BITS-1:0];
            next_state.privileged = hprot[1];
            next_state.phase      = hwrite ? PHASE_WRITE : PHASE_READ;
            if (!hwrite) begin
                // reads open to both modes, no fault raised
                case (haddr[perf_monitor_pkg::ADDR_BITS-1:0])
                    perf_monitor_pkg::ADDR_CONTROL: next_state.rdata = state.control;
                    perf_monitor_pkg::ADDR_CYCLE:   next_state.rdata = 32'(next_state.cycles);
                    default:                        next_state.rdata = '0;
                endcase
            end
        end else if (hready) begin
            next_state.phase = PHASE_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state.phase      <= PHASE_IDLE;
            state.addr       <= '0;
            state.privileged <= 1'b0;
            state.control    <= perf_monitor_pkg::CONTROL_RESET;
            state.cycles     <= '0;
            state.fault      <= 1'b0;
            state.rdata      <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // counter read data come from the bank register, others from the local one
    assign hrdata = (state.phase == PHASE_READ && counter_hit(state.addr))
                    ? 32'(count_rdata) : state.rdata;
    assign hreadyout                 = 1'b1;
    assign hresp                     = 1'b0;
    assign control_space_write_fault = state.fault;

endmodule

//--- performance_event_monitor_test.sv
// testbench: register access, event selection and counter checks
`timescale 1ns/100ps

module performance_event_monitor_test;
    localparam logic [7:0] CTL = perf_monitor_pkg::ADDR_CONTROL;
    localparam logic [7:0] CYC = perf_monitor_pkg::ADDR_CYCLE;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [3:0]  hprot;
    logic [31:0] hwdata;
    wire         hready;
    logic [31:0] hrdata;
    logic        hresp;
    logic        fault;
    logic        ev_start;
    logic [15:0] ev_mask;
    logic [7:0]  ev_count;
    logic        ev_busy;
    perf_monitor_pkg::event_pulses_s events;
    int          err_count;
    int          cmp_count;
    logic [31:0] rd;
    logic [31:0] t0;
    logic [4:0]  s;

    performance_event_monitor u_performance_event_monitor (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hprot(hprot), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .events(events), .control_space_write_fault(fault)
    );
    event_source_model u_event_source_model (
        .hclk(hclk), .hresetn(hresetn), .start(ev_start), .mask(ev_mask), .count(ev_count),
        .gap(4'h1), .events(events), .busy(ev_busy)
    );

    // ----
    // bus and compare tasks
    // ----
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // bounded wait so a stuck slave ends the run instead of hanging it
    task automatic wait_sig(input int which);
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while ((which == 0 ? hready !== 1'b1 : ev_busy !== 1'b0) && n < 100);
        if (n >= 100) begin
            err_count++;
            final_report();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic sup,
                       input logic fire);
        @(posedge hclk);
        hsel     <= 1'b1;
        haddr    <= {24'h000000, a};
        htrans   <= 2'h2;
        hwrite   <= wr;
        hprot    <= {2'b00, sup, 1'b1};
        ev_start <= fire;
        wait_sig(0);
        hsel     <= 1'b0;
        htrans   <= 2'h0;
        hwdata   <= wd;
        ev_start <= 1'b0;
        wait_sig(0);
        rd = hrdata;
    endtask

    task automatic expect_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 1'b1, 1'b0);
        chk(what, exp, rd);
    endtask

    function automatic logic [7:0] ca(input int k);
        ca = perf_monitor_pkg::ADDR_COUNT0 + 8'(k * perf_monitor_pkg::COUNTER_STEP);
    endfunction

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // ----
    // main sequence
    // ----
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hprot = 4'h3;
        hwdata = 32'h0;
        ev_start = 1'b0;
        ev_mask = 16'h0000;
        ev_count = 8'h03;
        err_count = 0;
        cmp_count = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        expect_rd("control", CTL, 32'h0);
        expect_rd("unmapped", perf_monitor_pkg::ADDR_STATUS, 32'h0);
        bus(1'b1, CTL, 32'hFFFF_FFFF, 1'b1, 1'b0);
        expect_rd("control", CTL, 32'hFFFF_F001);
        bus(1'b0, CYC, 32'h0, 1'b1, 1'b0);
        t0 = rd;
        expect_rd("cycle step", CYC, t0 + 32'h3);
        bus(1'b1, CTL, 32'h0, 1'b0, 1'b0);
        bus(1'b0, CTL, 32'h0, 1'b0, 1'b0);
        chk("control after user write", 32'hFFFF_F001, rd);
        // a nonzero counter, so that the clear below has something to zero
        bus(1'b1, ca(2), 32'h0000_00AA, 1'b1, 1'b0);
        expect_rd("loaded count", ca(2), 32'h0000_00AA);
        bus(1'b1, CTL, 32'h0000_0002, 1'b1, 1'b0);
        bus(1'b1, CYC, 32'h0000_0055, 1'b1, 1'b0);
        expect_rd("cycle", CYC, 32'h0);
        for (int k = 0; k < 4; k++) begin
            expect_rd("event count", ca(k), 32'h0);
        end
        // every encoding: counter 0 and 3 select it, 1 the reserved twin, 2 a neighbour
        for (int e = 0; e < 16; e++) begin
            s = 5'(e);
            ev_mask <= 16'h0001 << e;
            bus(1'b1, CTL, {s, {1'b0, s[3:0] + 4'h1}, s | 5'h10, s, 10'h000, 2'b11}, 1'b1, 1'b0);
            bus(1'b0, CTL, 32'h0, 1'b1, 1'b1);
            wait_sig(1);
            bus(1'b1, CTL, {s, {1'b0, s[3:0] + 4'h1}, s | 5'h10, s, 12'h000}, 1'b1, 1'b0);
            expect_rd("selected count", ca(0), 32'h3);
            expect_rd("reserved count", ca(1), 32'h0);
            expect_rd("other count", ca(2), 32'h0);
            expect_rd("selected count", ca(3), 32'h3);
        end
        ev_mask <= 16'h0001;
        bus(1'b1, CTL, 32'h0, 1'b1, 1'b0);
        bus(1'b1, ca(0), 32'hFFFF_FFFE, 1'b1, 1'b0);
        bus(1'b1, ca(1), 32'h0, 1'b1, 1'b0);
        // user-mode write to a counter must leave the loaded zero in place
        bus(1'b1, ca(1), 32'h0000_0077, 1'b0, 1'b0);
        bus(1'b1, CTL, 32'h1, 1'b1, 1'b0);
        bus(1'b0, CTL, 32'h0, 1'b1, 1'b1);
        wait_sig(1);
        bus(1'b1, CTL, 32'h0, 1'b1, 1'b0);
        expect_rd("wrapped count", ca(0), 32'h1);
        expect_rd("loaded count", ca(1), 32'h3);
        // one pulse lands on the very edge that writes counter 0
        ev_count <= 8'h01;
        bus(1'b1, CTL, 32'h1, 1'b1, 1'b0);
        bus(1'b1, ca(0), 32'h0000_0100, 1'b1, 1'b1);
        bus(1'b1, CTL, 32'h0, 1'b1, 1'b0);
        expect_rd("written count", ca(0), 32'h0000_0100);
        expect_rd("bumped count", ca(1), 32'h4);
        final_report();
    end
endmodule
